// *** logic/pllcg_pkg.sv ***
// constants, field layouts and carrier types of the pll clock generator
package pllcg_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [2:0] OFF_CTRL = 3'h0; // enable, flag, on, select, p, e
   localparam logic [2:0] OFF_BW = 3'h1; // auto, lock, filter mode
   localparam logic [2:0] OFF_MULT_LO = 3'h2; // feedback modulo n, low byte
   localparam logic [2:0] OFF_MULT_HI = 3'h3; // feedback modulo n, high nibble
   localparam logic [2:0] OFF_VRS = 3'h4; // vco linear range factor l
   localparam logic [2:0] OFF_RDIV = 3'h5; // reference divider r
   localparam logic [2:0] OFF_CFG = 3'h6; // stop-mode osc, raw osc source
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_IE = 7;
   localparam int CTRL_FLAG = 6;
   localparam int CTRL_ON = 5;
   localparam int CTRL_BCS = 4;
   localparam int CTRL_P = 2; // two bits from here
   localparam int CTRL_E = 0; // two bits from here
   localparam int BW_AUTO = 7;
   localparam int BW_LOCK = 6;
   localparam int BW_ACQ = 5;
   localparam int CFG_OSC_STOP = 0;
   localparam int CFG_RAW_OSC = 1;
   // ----------------------------------------
   // reset values and timing counts
   // ----------------------------------------
   localparam logic [11:0] RST_N = 12'h001;
   localparam logic [7:0] RST_L = 8'h00;
   localparam logic [3:0] RST_R = 4'h1;
   localparam logic [2:0] LOCK_RUNS = 3'h4; // good periods before lock
   localparam logic [16:0] F_NOM_KHZ = 17'h0007D; // 125 khz step
   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic int_enable;
      logic int_flag;
      logic pll_on;
      logic base_sel;
      logic [1:0] p;
      logic [1:0] e;
      logic auto_bw;
      logic acq_manual;
      logic [11:0] n;
      logic [7:0] l;
      logic [3:0] r;
      logic osc_stop_en;
      logic raw_osc;
   } pllcg_regs_t;
   typedef enum logic {LD_ACQ, LD_TRACK} pllcg_ld_t;
endpackage

// *** logic/pllcg_top.sv ***
// pll clock generator control: dividers, detectors, selector, registers
`timescale 1ns/100ps
// What this block does
// - base clock from osc/2 or vco/3
// - bus tick at half the base or raw oscillator rate
// - system clocks from base or raw oscillator
// - interrupt enable forced zero while auto off
// - flag and lock read zero while auto off
// - select held zero if pll off, l zero
// - programming registers read-only while pll on
// - pll on forced one while select set
// - reference divided by modulo r
// - vco prescaled by 2^p, then modulo n
// - phase detector emits up/down correction pulses
// - lock detector compares frequencies per reference tick
// - filter mode automatic or software controlled
// - interrupt on lock entry and exit
// - config bit keeps oscillator running in stop
// - center frequency equals l times 2^e times 125k, wrapped to 17 bits
// - reference is buffered oscillator, also timebase
// - filter mode reads 0 acquire, 1 track
// - lock follows tolerance in automatic mode
// - each lock toggle requests interrupt when enabled
module pllcg_top
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic osc_clock, // oscillator pin, asynchronous
   input wire logic vco_clock, // vco output, asynchronous
   input wire logic stop_mode, // device in stop mode
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   output logic base_clock_out, // one pulse per base clock period
   output logic bus_clock_tick, // one pulse per bus clock period
   output logic pll_ref_clock, // buffered oscillator edge
   output logic timebase_clock, // oscillator edge to timebase
   output logic final_ref_clock,
   output logic vco_feedback_clock,
   output logic pd_up, // correction pulse, speed up
   output logic pd_down, // correction pulse, slow down
   output logic filter_track, // loop filter in tracking mode
   output logic pll_irq, // interrupt request level
   output logic osc_enable, // oscillator power
   output logic [16:0] vco_center_khz
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic osc_meta, osc_sync, osc_prev; // meta read only by sync
   logic vco_meta, vco_sync, vco_prev;
   logic osc_tick, vco_tick;
   // two flops before any logic, then an edge detector
   always_ff @(posedge sys_clk)
   begin
      osc_meta <= osc_clock;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      vco_meta <= vco_clock;
      vco_sync <= vco_meta;
      vco_prev <= vco_sync;
   end
   assign osc_tick = osc_sync & ~osc_prev;
   assign vco_tick = vco_sync & ~vco_prev;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   pllcg_pkg::pllcg_regs_t regs, next_regs;
   logic lock, next_lock; // lock indicator
   logic lock_chg; // lock toggled this cycle
   logic [7:0] next_rdata;
   logic wr_ctrl;
   assign wr_ctrl = wr_en && addr == pllcg_pkg::OFF_CTRL;
   // write decode with the interlocks between bits
   always_comb
   begin
      next_regs = regs;
      if (wr_ctrl)
      begin
         next_regs.int_enable = wdata[pllcg_pkg::CTRL_IE];
         // pll on cannot drop while the vco drives base clock
         next_regs.pll_on = regs.base_sel | wdata[pllcg_pkg::CTRL_ON];
         // select only writable when pll on and range nonzero
         next_regs.base_sel = wdata[pllcg_pkg::CTRL_BCS];
         if (!regs.pll_on)
         begin
            next_regs.p = wdata[pllcg_pkg::CTRL_P +: 2];
            next_regs.e = wdata[pllcg_pkg::CTRL_E +: 2];
         end
      end
      if (wr_en && !regs.pll_on)
      begin
         unique case (addr)
            pllcg_pkg::OFF_MULT_LO: next_regs.n[7:0] = wdata;
            pllcg_pkg::OFF_MULT_HI: next_regs.n[11:8] = wdata[3:0];
            pllcg_pkg::OFF_VRS: next_regs.l = wdata;
            pllcg_pkg::OFF_RDIV: next_regs.r = wdata[3:0];
            default: ; // other offsets handled elsewhere
         endcase
      end
      if (wr_en && addr == pllcg_pkg::OFF_BW)
      begin
         next_regs.auto_bw = wdata[pllcg_pkg::BW_AUTO];
         // filter mode bit read-only in automatic mode
         if (!wdata[pllcg_pkg::BW_AUTO] && !regs.auto_bw)
            next_regs.acq_manual = wdata[pllcg_pkg::BW_ACQ];
      end
      if (wr_en && addr == pllcg_pkg::OFF_CFG)
      begin
         next_regs.osc_stop_en = wdata[pllcg_pkg::CFG_OSC_STOP];
         next_regs.raw_osc = wdata[pllcg_pkg::CFG_RAW_OSC];
      end
      // write one to acknowledge, a new toggle wins over it
      if (wr_ctrl && wdata[pllcg_pkg::CTRL_FLAG])
         next_regs.int_flag = 1'b0;
      if (lock_chg && regs.auto_bw)
         next_regs.int_flag = 1'b1;
      // forced values, stronger than any write
      if (!regs.pll_on || regs.l == 8'h00)
         next_regs.base_sel = 1'b0;
      if (!next_regs.pll_on)
         next_regs.base_sel = 1'b0;
      if (!next_regs.auto_bw)
      begin
         next_regs.int_enable = 1'b0;
         next_regs.int_flag = 1'b0;
      end
   end
   // read mux, data one cycle after the strobe
   always_comb
   begin
      next_rdata = 8'h00;
      if (rd_en)
      begin
         unique case (addr)
            pllcg_pkg::OFF_CTRL: next_rdata = {regs.int_enable,
               regs.int_flag, regs.pll_on, regs.base_sel, regs.p, regs.e};
            pllcg_pkg::OFF_BW: next_rdata = {regs.auto_bw,
               lock & regs.auto_bw, filter_track, 5'h00};
            pllcg_pkg::OFF_MULT_LO: next_rdata = regs.n[7:0];
            pllcg_pkg::OFF_MULT_HI: next_rdata = {4'h0, regs.n[11:8]};
            pllcg_pkg::OFF_VRS: next_rdata = regs.l;
            pllcg_pkg::OFF_RDIV: next_rdata = {4'h0, regs.r};
            pllcg_pkg::OFF_CFG: next_rdata = {6'h00, regs.raw_osc,
               regs.osc_stop_en};
            default: next_rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end
   // register the file; reset leaves the pll off on oscillator
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         regs <= '0;
         regs.n <= pllcg_pkg::RST_N;
         regs.l <= pllcg_pkg::RST_L;
         regs.r <= pllcg_pkg::RST_R;
         rdata <= 8'h00;
      end
      else
      begin
         regs <= next_regs;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // pll dividers and phase detector
   // ----------------------------------------
   logic [3:0] rcnt, next_rcnt;
   logic [2:0] pcnt, next_pcnt;
   logic [11:0] ncnt, next_ncnt;
   logic ref_t, fb_t, pcl_t; // divider output events
   logic next_up, next_down;
   logic [2:0] pmax;
   assign pmax = 3'(({1'b0, 2'b0} | 3'h1) << regs.p) - 3'h1;
   // dividers count only while the pll is on
   always_comb
   begin
      next_rcnt = rcnt;
      next_pcnt = pcnt;
      next_ncnt = ncnt;
      ref_t = 1'b0;
      pcl_t = 1'b0;
      fb_t = 1'b0;
      if (osc_tick)
      begin
         // r of zero behaves as one, no stuck divider
         if (rcnt + 4'h1 >= regs.r)
         begin
            next_rcnt = 4'h0;
            ref_t = 1'b1;
         end
         else
            next_rcnt = rcnt + 4'h1;
      end
      if (vco_tick)
      begin
         if (pcnt == pmax)
         begin
            next_pcnt = 3'h0;
            pcl_t = 1'b1;
         end
         else
            next_pcnt = pcnt + 3'h1;
      end
      if (pcl_t)
      begin
         if (ncnt + 12'h001 >= regs.n)
         begin
            next_ncnt = 12'h000;
            fb_t = 1'b1;
         end
         else
            next_ncnt = ncnt + 12'h001;
      end
      if (!regs.pll_on)
      begin
         next_rcnt = 4'h0;
         next_pcnt = 3'h0;
         next_ncnt = 12'h000;
         ref_t = 1'b0;
         fb_t = 1'b0;
      end
      // leading edge raises its side; the lagging edge clears it and
      // never raises its own, so the width tracks the phase gap
      next_up = (pd_up | ref_t) & ~(pd_down | fb_t);
      next_down = (pd_down | fb_t) & ~(pd_up | ref_t);
   end
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rcnt <= 4'h0;
         pcnt <= 3'h0;
         ncnt <= 12'h000;
         pd_up <= 1'b0;
         pd_down <= 1'b0;
         final_ref_clock <= 1'b0;
         vco_feedback_clock <= 1'b0;
      end
      else
      begin
         rcnt <= next_rcnt;
         pcnt <= next_pcnt;
         ncnt <= next_ncnt;
         pd_up <= next_up;
         pd_down <= next_down;
         final_ref_clock <= ref_t;
         vco_feedback_clock <= fb_t;
      end
   end

   // ----------------------------------------
   // lock detector and filter mode
   // ----------------------------------------
   pllcg_pkg::pllcg_ld_t ld_st, next_ld_st;
   logic [1:0] fb_seen, next_fb_seen; // feedback events this period
   logic [2:0] good, next_good; // consecutive matching periods
   logic next_track;
   // one feedback per reference period means frequencies match
   always_comb
   begin
      next_ld_st = ld_st;
      next_good = good;
      next_fb_seen = fb_seen;
      if (fb_t && fb_seen != 2'h3)
         next_fb_seen = fb_seen + 2'h1;
      if (ref_t)
      begin
         next_fb_seen = {1'b0, fb_t};
         if (fb_seen == 2'h1 && good != pllcg_pkg::LOCK_RUNS)
            next_good = good + 3'h1;
         else if (fb_seen != 2'h1)
            next_good = 3'h0;
      end
      unique case (ld_st)
         pllcg_pkg::LD_ACQ:
            if (next_good == pllcg_pkg::LOCK_RUNS)
               next_ld_st = pllcg_pkg::LD_TRACK;
         pllcg_pkg::LD_TRACK:
            if (next_good == 3'h0)
               next_ld_st = pllcg_pkg::LD_ACQ;
      endcase
      if (!regs.pll_on)
      begin
         next_ld_st = pllcg_pkg::LD_ACQ;
         next_good = 3'h0;
         next_fb_seen = 2'h0;
      end
      next_lock = next_ld_st == pllcg_pkg::LD_TRACK;
      // automatic follows the detector, manual follows software
      next_track = regs.auto_bw ? next_lock : regs.acq_manual;
   end
   assign lock_chg = next_lock != lock;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ld_st <= pllcg_pkg::LD_ACQ;
         good <= 3'h0;
         fb_seen <= 2'h0;
         lock <= 1'b0;
         filter_track <= 1'b0;
      end
      else
      begin
         ld_st <= next_ld_st;
         good <= next_good;
         fb_seen <= next_fb_seen;
         lock <= next_lock;
         filter_track <= next_track;
      end
   end

   // ----------------------------------------
   // base clock selector and system clocks
   // ----------------------------------------
   logic [1:0] bcnt, next_bcnt;
   logic base_t, src_t, bus_ph, next_bus_ph;
   logic sel_d; // select of last cycle, restarts divider on change
   // osc/2 or vco/3; a select change restarts the divider at any point in its period
   always_comb
   begin
      base_t = 1'b0;
      next_bcnt = bcnt;
      if (regs.base_sel ? vco_tick : osc_tick)
      begin
         if (bcnt == (regs.base_sel ? 2'h2 : 2'h1))
         begin
            next_bcnt = 2'h0;
            base_t = 1'b1;
         end
         else
            next_bcnt = bcnt + 2'h1;
      end
      if (sel_d != regs.base_sel)
         next_bcnt = 2'h0;
      src_t = regs.raw_osc ? osc_tick : base_t;
      next_bus_ph = src_t ? ~bus_ph : bus_ph;
   end
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         bcnt <= 2'h0;
         sel_d <= 1'b0;
         bus_ph <= 1'b0;
         base_clock_out <= 1'b0;
         bus_clock_tick <= 1'b0;
         pll_ref_clock <= 1'b0;
         timebase_clock <= 1'b0;
         pll_irq <= 1'b0;
         osc_enable <= 1'b1;
         vco_center_khz <= 17'h00000;
      end
      else
      begin
         bcnt <= next_bcnt;
         sel_d <= regs.base_sel;
         bus_ph <= next_bus_ph;
         base_clock_out <= base_t;
         bus_clock_tick <= src_t & bus_ph;
         pll_ref_clock <= osc_tick;
         timebase_clock <= osc_tick;
         pll_irq <= regs.int_flag & regs.int_enable;
         osc_enable <= ~stop_mode | regs.osc_stop_en;
         vco_center_khz <= 17'(({9'h000, regs.l} << regs.e)
            * pllcg_pkg::F_NOM_KHZ);
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_ie_forced;
      !regs.auto_bw |-> !regs.int_enable;
   endproperty
   a_ie_forced: assert property (p_ie_forced)
      else $error("int enable set while auto off");
   property p_lock_read;
      rd_en && addr == pllcg_pkg::OFF_BW && !regs.auto_bw
         |=> !rdata[pllcg_pkg::BW_LOCK];
   endproperty
   a_lock_read: assert property (p_lock_read)
      else $error("lock read set while auto off");
   property p_bcs_hold;
      !regs.pll_on |-> !regs.base_sel;
   endproperty
   a_bcs_hold: assert property (p_bcs_hold)
      else $error("select set while pll off");
   property p_prog_ro;
      regs.pll_on && wr_en |=> $stable(regs.n) && $stable(regs.l);
   endproperty
   a_prog_ro: assert property (p_prog_ro)
      else $error("programming changed while pll on");
   property p_on_forced;
      regs.base_sel |=> regs.pll_on;
   endproperty
   a_on_forced: assert property (p_on_forced)
      else $error("pll dropped while select set");
   property p_irq_pair;
      regs.int_flag && regs.int_enable |=> pll_irq;
   endproperty
   a_irq_pair: assert property (p_irq_pair)
      else $error("irq not raised for enabled flag");
   sequence s_toggle;
      regs.auto_bw && lock_chg;
   endsequence
   property p_flag_set;
      s_toggle ##1 regs.auto_bw |-> regs.int_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag missed lock toggle");
   property p_osc_base;
      !regs.base_sel && !sel_d && osc_tick && bcnt == 2'h1
         |=> base_clock_out;
   endproperty
   a_osc_base: assert property (p_osc_base)
      else $error("osc half base tick missing");
   property p_ref_off;
      !regs.pll_on |=> !final_ref_clock;
   endproperty
   a_ref_off: assert property (p_ref_off)
      else $error("reference ticks while pll off");
endmodule

// *** testbench/pllcg_src_model.sv ***
// oscillator and vco sources standing in front of the clock generator
`timescale 1ns/100ps
module pllcg_src_model
(
   input wire logic vco_run,
   output logic osc_clock,
   output logic vco_clock
);
   // ----------------------------------------
   // oscillator, 2.5 mhz, always running
   // ----------------------------------------
   // slow enough that the bus stays far under its ceiling
   initial
   begin
      osc_clock = 1'b0;
      #5;
      forever
      begin
         #200;
         osc_clock = ~osc_clock;
      end
   end
   // ----------------------------------------
   // vco, twice the oscillator rate
   // ----------------------------------------
   // stands low when stopped, so a lost lock really loses its edges
   initial
   begin
      vco_clock = 1'b0;
      #30;
      forever
      begin
         #100;
         vco_clock = vco_run ? ~vco_clock : 1'b0;
      end
   end
endmodule

// *** testbench/test_pll_clock_generator.sv ***
// self-checking bench for the pll clock generator
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
   begin \
      comparisons++; \
      if ((gt) !== (ex)) \
      begin \
         bad_count++; \
         $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module test_pll_clock_generator;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic sys_clk, reset, stop_mode, wr_en, rd_en, vco_run;
   logic osc_clock, vco_clock; // from the source model
   logic [2:0] addr;
   logic [7:0] wdata, rdata, e_rd, l_val, pe, n_lo;
   logic [1:0] e_val, p_val;
   logic base_clock_out, bus_clock_tick, pll_ref_clock, timebase_clock;
   logic final_ref_clock, vco_feedback_clock, pd_up, pd_down;
   logic filter_track, pll_irq, osc_enable, rd_pend;
   logic [16:0] vco_center_khz, e_ctr; // e_ctr: expected center
   logic [7:0] exp_q[$]; // expected read data, oldest first
   int bad_count, comparisons, cycles, seed;
   // ----------------------------------------
   // design and sources
   // ----------------------------------------
   pllcg_src_model src (.vco_run(vco_run), .osc_clock(osc_clock),
      .vco_clock(vco_clock));
   pllcg_top uut (.sys_clk(sys_clk), .reset(reset), .osc_clock(osc_clock),
      .vco_clock(vco_clock), .stop_mode(stop_mode), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .base_clock_out(base_clock_out), .bus_clock_tick(bus_clock_tick),
      .pll_ref_clock(pll_ref_clock), .timebase_clock(timebase_clock),
      .final_ref_clock(final_ref_clock),
      .vco_feedback_clock(vco_feedback_clock), .pd_up(pd_up),
      .pd_down(pd_down), .filter_track(filter_track), .pll_irq(pll_irq),
      .osc_enable(osc_enable), .vco_center_khz(vco_center_khz));
   // 40 mhz system clock
   initial
   begin
      sys_clk = 1'b0;
      forever
         #12.5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // read monitor and hang guard
   // ----------------------------------------
   // read data stand only in the cycle after the strobe
   always @(posedge sys_clk)
   begin
      rd_pend <= rd_en;
      if (rd_pend === 1'b1)
      begin
         e_rd = exp_q.pop_front();
         `CHK("rdata", e_rd, rdata)
      end
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   // note the expectation, the monitor checks it a cycle later
   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      @(posedge sys_clk);
      exp_q.push_back(x);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
   endtask
   // bounded wait for the filter mode output
   task automatic wait_track(input logic v);
      for (int i = 0; i < 400 && filter_track !== v; i++)
         @(negedge sys_clk);
      `CHK("filter_track", v, filter_track)
   endtask
   function automatic logic in_rng(input int v, input int lo, input int hi);
      return (v >= lo && v <= hi);
   endfunction
   // count pulses over 40 oscillator periods; sync jitter allows one
   task automatic window(input int blo, input int bhi, input int ulo,
      input int uhi);
      int c[9];
      c = '{default: 0};
      repeat (640)
      begin
         @(posedge sys_clk);
         c[0] += base_clock_out;
         c[1] += bus_clock_tick;
         c[2] += pll_ref_clock;
         c[3] += timebase_clock;
         c[4] += final_ref_clock;
         c[5] += vco_feedback_clock;
         c[6] += pd_up;
         c[7] += pd_down;
         c[8] += pd_up & pd_down;
      end
      `CHK("base_clock_out", 1'b1, in_rng(c[0], blo, bhi))
      `CHK("bus_clock_tick", 1'b1, in_rng(c[1], ulo, uhi))
      `CHK("pll_ref_clock", 1'b1, in_rng(c[2], 39, 41))
      `CHK("timebase_clock", 1'b1, in_rng(c[3], 39, 41))
      `CHK("final_ref_clock", 1'b1, in_rng(c[4], 39, 41))
      `CHK("vco_feedback_clock", 1'b1, in_rng(c[5], 39, 41))
      // edges 3 or 5 cycles apart: 120 or 200 correction cycles
      `CHK("pd_width", 1'b1, in_rng(c[6] + c[7], 110, 210))
      `CHK("pd_overlap", 32'h0, c[8])
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      reset = 1'b1;
      stop_mode = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      vco_run = 1'b1;
      rd_pend = 1'b0;
      seed = $urandom(38);
      l_val = 8'($urandom_range(255, 1));
      e_val = 2'($urandom_range(2, 0));
      p_val = 2'($urandom_range(1, 0));
      pe = {4'h0, p_val, e_val};
      n_lo = p_val[0] ? 8'h01 : 8'h02; // 2^p times n stays two
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      // reset values, unmapped offset 7 included
      foreach (exp_q[i]) ;
      for (int a = 0; a < 8; a++)
         rd(3'(a), (a == 2 || a == 5) ? 8'h01 : 8'h00);
      // oscillator power in stop mode
      `CHK("osc_enable", 1'b1, osc_enable)
      stop_mode <= 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK("osc_enable", 1'b0, osc_enable)
      wr(pllcg_pkg::OFF_CFG, 8'h01);
      // bit lands at the task's last edge, the output one cycle later
      repeat (2) @(negedge sys_clk);
      `CHK("osc_enable", 1'b1, osc_enable)
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      wr(pllcg_pkg::OFF_CFG, 8'h00);
      // interlocks with auto and pll off
      wr(pllcg_pkg::OFF_CTRL, 8'h80);
      rd(pllcg_pkg::OFF_CTRL, 8'h00);
      wr(pllcg_pkg::OFF_CTRL, 8'h10);
      rd(pllcg_pkg::OFF_CTRL, 8'h00);
      // manual filter mode, pll still off
      wr(pllcg_pkg::OFF_BW, 8'h20);
      wait_track(1'b1);
      rd(pllcg_pkg::OFF_BW, 8'h20);
      wr(pllcg_pkg::OFF_BW, 8'h00); // clear before enabling
      wait_track(1'b0);
      // programming, r of one as for a crystal
      wr(pllcg_pkg::OFF_RDIV, 8'h01);
      wr(pllcg_pkg::OFF_MULT_LO, n_lo);
      wr(pllcg_pkg::OFF_MULT_HI, 8'h00);
      wr(pllcg_pkg::OFF_VRS, l_val);
      wr(pllcg_pkg::OFF_CTRL, pe);
      // e lands at the task's last edge, the product one cycle later
      repeat (2) @(negedge sys_clk);
      e_ctr = (17'(l_val) << e_val) * pllcg_pkg::F_NOM_KHZ;
      `CHK("center", e_ctr, vco_center_khz)
      wr(pllcg_pkg::OFF_CTRL, 8'h20 | pe);
      wr(pllcg_pkg::OFF_VRS, ~l_val);
      rd(pllcg_pkg::OFF_VRS, l_val);
      window(19, 21, 9, 11);
      // automatic mode and lock entry; the loop locked in manual mode,
      // so restart it to make the lock toggle while auto is set
      wr(pllcg_pkg::OFF_CTRL, pe);
      wr(pllcg_pkg::OFF_BW, 8'h80);
      wr(pllcg_pkg::OFF_CTRL, 8'hA0 | pe);
      wait_track(1'b1);
      rd(pllcg_pkg::OFF_BW, 8'hE0);
      rd(pllcg_pkg::OFF_CTRL, 8'hE0 | pe);
      `CHK("pll_irq", 1'b1, pll_irq)
      wr(pllcg_pkg::OFF_CTRL, 8'hE0 | pe);
      rd(pllcg_pkg::OFF_CTRL, 8'hA0 | pe);
      `CHK("pll_irq", 1'b0, pll_irq)
      // vco as base clock, pll on held
      wr(pllcg_pkg::OFF_CTRL, 8'hB0 | pe);
      rd(pllcg_pkg::OFF_CTRL, 8'hB0 | pe);
      // keep select, try to drop pll on: the on bit must hold
      wr(pllcg_pkg::OFF_CTRL, 8'h90 | pe);
      rd(pllcg_pkg::OFF_CTRL, 8'hB0 | pe);
      window(25, 28, 12, 14);
      wr(pllcg_pkg::OFF_CFG, 8'h02);
      window(25, 28, 19, 21);
      wr(pllcg_pkg::OFF_CFG, 8'h00);
      // lock lost when the vco stops
      vco_run <= 1'b0;
      wait_track(1'b0);
      rd(pllcg_pkg::OFF_BW, 8'h80);
      rd(pllcg_pkg::OFF_CTRL, 8'hF0 | pe);
      `CHK("pll_irq", 1'b1, pll_irq)
      // manual again: enable and flag forced low
      wr(pllcg_pkg::OFF_BW, 8'h00);
      rd(pllcg_pkg::OFF_CTRL, 8'h30 | pe);
      repeat (3) @(posedge sys_clk);
      `CHK("pll_irq", 1'b0, pll_irq)
      print_verdict();
   end
endmodule
